// file: rtl/gpio_port_config_lock.sv
// Sixteen-pin general-purpose port with mode, drive, slew, pull,
// alternate-function selection and a configuration freeze.
// Assumes register port, peripheral reset and oscillator controls are
// synchronous to mclk_i; pin inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Freeze blocks locked pins in config registers
// - Key on bit 16, mask held constant
// - Freeze lasts until device or peripheral reset
// - Key written 1,0,1; any error aborts
// - Freeze bits writable only while key 0
// - One selector serves alt input and output
// - Four-bit selector, low and high registers
// - Input mode: driver off, Schmitt on, pulls
// - Pins sampled every clock into input register
// - Open drain drives low, never high
// - Push-pull drives both levels
// - Output register reads last written value
// - Alt mode: peripheral drives enable and data
// - Analog: driver, Schmitt, pulls off, reads 0
// - Enabled oscillator owns its in pin, and its out pin unless bypassed
// - Backup pins analog when core powered off, unless rtc_bypass_i set
// - Byte, half-word and word writes
// - Mode field: input, output, alt, analog
// - Slew field: x0 low, 01 medium, 11 high
// - Pull field: none, up, down
// - Mode register reset per port kind
// - Slew register reset per port kind
// - Pull register reset per port kind
// - Data registers use bits 15:0 only
module gpio_port_config_lock
  import gpio_lock_pkg::*;
#(
  parameter port_kind_t  PORT_KIND        = PORT_OTHER,
  parameter logic [15:0] BACKUP_PINS      = 16'h0000,
  parameter int          FAST_OSC_IN_PIN  = 0,
  parameter int          FAST_FAST_OSC_OUTPUT_PIN_PIN = 1,
  parameter int          SLOW_OSC_IN_PIN  = 14,
  parameter int          SLOW_FAST_OSC_OUTPUT_PIN_PIN = 15
) (
  input  wire logic         mclk_i,
  input  wire logic         arst_n_i,
  input  wire logic         periph_rst_i,
  input  wire logic         reg_sel_i,
  input  wire logic         reg_wr_i,
  input  wire logic [5:0]   reg_addr_i,
  input  wire logic [3:0]   reg_be_i,
  input  wire logic [31:0]  reg_wdata_i,
  output logic      [31:0]  reg_rdata_o,
  output logic              reg_ack_o,
  input  wire logic [15:0]  pin_in_i,
  output logic      [15:0]  pin_out_o,
  output logic      [15:0]  pin_oe_o,
  output logic      [15:0]  pull_up_o,
  output logic      [15:0]  pull_down_o,
  output logic      [15:0]  schmitt_en_o,
  output logic      [15:0]  slew_medium_o,
  output logic      [15:0]  slew_high_o,
  input  wire logic [255:0] af_data_i,
  input  wire logic [255:0] af_oe_i,
  output logic      [255:0] af_in_o,
  input  wire logic         fast_osc_enable_i,
  input  wire logic         fast_osc_bypass_i,
  input  wire logic         slow_osc_enable_i,
  input  wire logic         slow_osc_bypass_i,
  input  wire logic         core_off_i,
  input  wire logic [15:0]  rtc_bypass_i
);

  // ********
  // Helper functions
  // ********
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] spread2(input logic [15:0] f);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      m[2*i +: 2] = {2{f[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] spread4(input logic [7:0] f);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      m[4*i +: 4] = {4{f[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [31:0] kind_rst(input logic [31:0] a_v,
                                           input logic [31:0] b_v);
    if (PORT_KIND == PORT_A) begin
      return a_v;
    end else if (PORT_KIND == PORT_B) begin
      return b_v;
    end else begin
      return ZERO_RST;
    end
  endfunction

  localparam logic [31:0] MODE_RST = kind_rst(MODE_RST_A, MODE_RST_B);
  localparam logic [31:0] SLEW_RST = kind_rst(SLEW_RST_A, SLEW_RST_B);
  localparam logic [31:0] PULL_RST = kind_rst(PULL_RST_A, PULL_RST_B);

  // ********
  // Register state
  // ********
  logic [31:0] mode_r,   mode_nxt;
  logic [15:0] drive_r,  drive_nxt;
  logic [31:0] slew_r,   slew_nxt;
  logic [31:0] pull_r,   pull_nxt;
  logic [15:0] outv_r,   outv_nxt;
  logic [31:0] af_lo_r,  af_lo_nxt;
  logic [31:0] af_hi_r,  af_hi_nxt;
  logic [15:0] fbits_r,  fbits_nxt;
  logic        key_r,    key_nxt;
  freeze_seq_e seq_r,    seq_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  logic        ack_r,    ack_nxt;

  logic        wr_en;
  logic [31:0] bmask;
  logic [15:0] frozen;
  logic        same_mask;
  logic [15:0] inval_r;

  assign wr_en     = reg_sel_i & reg_wr_i;
  assign bmask     = lane_mask(reg_be_i);
  assign frozen    = key_r ? fbits_r : 16'h0000;
  assign same_mask = (reg_wdata_i[15:0] == fbits_r);

  // ********
  // Register writes and freeze sequence
  // ********
  always_comb begin
    mode_nxt  = mode_r;
    drive_nxt = drive_r;
    slew_nxt  = slew_r;
    pull_nxt  = pull_r;
    outv_nxt  = outv_r;
    af_lo_nxt = af_lo_r;
    af_hi_nxt = af_hi_r;
    fbits_nxt = fbits_r;
    key_nxt   = key_r;
    seq_nxt   = seq_r;
    if (wr_en) begin
      case (reg_addr_i)
        OFS_MODE: begin
          mode_nxt = merge(mode_r, reg_wdata_i, bmask & ~spread2(frozen));
        end
        OFS_DRIVE: begin
          drive_nxt = 16'(merge({16'h0000, drive_r}, reg_wdata_i, bmask & {16'h0000, ~frozen}));
        end
        OFS_SLEW: begin
          slew_nxt = merge(slew_r, reg_wdata_i, bmask & ~spread2(frozen));
        end
        OFS_PULL: begin
          pull_nxt = merge(pull_r, reg_wdata_i, bmask & ~spread2(frozen));
        end
        OFS_OUTPUT: begin
          outv_nxt = 16'(merge({16'h0000, outv_r}, reg_wdata_i, bmask));
        end
        OFS_AF_LO: begin
          af_lo_nxt = merge(af_lo_r, reg_wdata_i, bmask & ~spread4(frozen[7:0]));
        end
        OFS_AF_HI: begin
          af_hi_nxt = merge(af_hi_r, reg_wdata_i, bmask & ~spread4(frozen[15:8]));
        end
        OFS_FREEZE: begin
          if (!key_r) begin
            fbits_nxt = 16'(merge({16'h0000, fbits_r}, reg_wdata_i, bmask));
            if (reg_be_i != FULL_WORD_BE) begin
              seq_nxt = FZ_IDLE;
            end else begin
              case (seq_r)
                FZ_IDLE: begin
                  seq_nxt = reg_wdata_i[FREEZE_KEY_POS] ? FZ_KEY_HI : FZ_IDLE;
                end
                FZ_KEY_HI: begin
                  seq_nxt = (!reg_wdata_i[FREEZE_KEY_POS] && same_mask) ? FZ_KEY_LO : FZ_IDLE;
                end
                FZ_KEY_LO: begin
                  seq_nxt = FZ_IDLE;
                  if (reg_wdata_i[FREEZE_KEY_POS] && same_mask) begin
                    key_nxt = 1'b1;
                  end
                end
                default: begin
                  seq_nxt = FZ_IDLE;
                end
              endcase
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (periph_rst_i) begin
      mode_nxt  = MODE_RST;
      drive_nxt = 16'h0000;
      slew_nxt  = SLEW_RST;
      pull_nxt  = PULL_RST;
      outv_nxt  = 16'h0000;
      af_lo_nxt = ZERO_RST;
      af_hi_nxt = ZERO_RST;
      fbits_nxt = 16'h0000;
      key_nxt   = 1'b0;
      seq_nxt   = FZ_IDLE;
    end
  end

  // ********
  // Register read
  // ********
  always_comb begin
    ack_nxt   = reg_sel_i & ~periph_rst_i;
    rdata_nxt = 32'h0000_0000;
    if (reg_sel_i && !reg_wr_i) begin
      case (reg_addr_i)
        OFS_MODE:   rdata_nxt = mode_r;
        OFS_DRIVE:  rdata_nxt = {16'h0000, drive_r};
        OFS_SLEW:   rdata_nxt = slew_r;
        OFS_PULL:   rdata_nxt = pull_r;
        OFS_INPUT:  rdata_nxt = {16'h0000, inval_r};
        OFS_OUTPUT: rdata_nxt = {16'h0000, outv_r};
        OFS_FREEZE: rdata_nxt = {15'h0000, key_r, fbits_r};
        OFS_AF_LO:  rdata_nxt = af_lo_r;
        OFS_AF_HI:  rdata_nxt = af_hi_r;
        default:    rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_r  <= MODE_RST;
      drive_r <= 16'h0000;
      slew_r  <= SLEW_RST;
      pull_r  <= PULL_RST;
      outv_r  <= 16'h0000;
      af_lo_r <= ZERO_RST;
      af_hi_r <= ZERO_RST;
      fbits_r <= 16'h0000;
      key_r   <= 1'b0;
      seq_r   <= FZ_IDLE;
      rdata_r <= 32'h0000_0000;
      ack_r   <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      drive_r <= drive_nxt;
      slew_r  <= slew_nxt;
      pull_r  <= pull_nxt;
      outv_r  <= outv_nxt;
      af_lo_r <= af_lo_nxt;
      af_hi_r <= af_hi_nxt;
      fbits_r <= fbits_nxt;
      key_r   <= key_nxt;
      seq_r   <= seq_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  // ********
  // Pin input synchroniser
  // ********
  logic [15:0] sync1_r, sync2_r, sync3_r, stable_r, stable_nxt;

  always_comb begin
    stable_nxt = stable_r;
    for (int p = 0; p < 16; p++) begin
      if (sync2_r[p] == sync3_r[p]) begin
        stable_nxt[p] = sync3_r[p];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r  <= 16'h0000;
      sync2_r  <= 16'h0000;
      sync3_r  <= 16'h0000;
      stable_r <= 16'h0000;
    end else begin
      sync1_r  <= pin_in_i;
      sync2_r  <= sync1_r;
      sync3_r  <= sync2_r;
      stable_r <= stable_nxt;
    end
  end

  // ********
  // Pin control
  // ********
  logic [15:0]  pout_r, pout_nxt, poe_r, poe_nxt, pup_r, pup_nxt, pdn_r, pdn_nxt;
  logic [15:0]  smt_r, smt_nxt, smed_r, smed_nxt, shigh_r, shigh_nxt, inval_nxt;
  logic [255:0] afin_r, afin_nxt;
  logic [15:0]  osc_own;
  logic [1:0]   md;
  logic [3:0]   afs;
  logic         dval;
  logic         den;

  always_comb begin
    osc_own = 16'h0000;
    if (fast_osc_enable_i) begin
      osc_own[FAST_OSC_IN_PIN] = 1'b1;
      osc_own[FAST_FAST_OSC_OUTPUT_PIN_PIN] = ~fast_osc_bypass_i;
    end
    if (slow_osc_enable_i) begin
      osc_own[SLOW_OSC_IN_PIN] = 1'b1;
      osc_own[SLOW_FAST_OSC_OUTPUT_PIN_PIN] = ~slow_osc_bypass_i;
    end
  end

  always_comb begin
    pout_nxt  = 16'h0000;
    poe_nxt   = 16'h0000;
    pup_nxt   = 16'h0000;
    pdn_nxt   = 16'h0000;
    smt_nxt   = 16'h0000;
    smed_nxt  = 16'h0000;
    shigh_nxt = 16'h0000;
    inval_nxt = 16'h0000;
    afin_nxt  = '0;
    md        = MODE_INPUT;
    afs       = 4'h0;
    dval      = 1'b0;
    den       = 1'b0;
    for (int p = 0; p < 16; p++) begin
      md  = mode_r[2*p +: 2];
      afs = (p < 8) ? af_lo_r[4*(p%8) +: 4] : af_hi_r[4*(p%8) +: 4];
      if (BACKUP_PINS[p] && core_off_i && !rtc_bypass_i[p]) begin
        md = MODE_ANALOG;
      end
      dval = 1'b0;
      den  = 1'b0;
      smt_nxt[p] = 1'b1;
      pup_nxt[p] = (pull_r[2*p] == 1'b1);
      pdn_nxt[p] = (pull_r[2*p+1] == 1'b1);
      case (md)
        MODE_INPUT: begin
          den = 1'b0;
        end
        MODE_OUTPUT: begin
          dval = outv_r[p];
          den  = 1'b1;
        end
        MODE_ALTFUNC: begin
          dval = af_data_i[16*p + int'(afs)];
          den  = af_oe_i[16*p + int'(afs)];
        end
        MODE_ANALOG: begin
          smt_nxt[p] = 1'b0;
          pup_nxt[p] = 1'b0;
          pdn_nxt[p] = 1'b0;
        end
        default: begin
          den = 1'b0;
        end
      endcase
      if (drive_r[p]) begin
        pout_nxt[p] = 1'b0;
        poe_nxt[p]  = den & ~dval;
      end else begin
        pout_nxt[p] = dval;
        poe_nxt[p]  = den;
      end
      if (osc_own[p]) begin
        poe_nxt[p] = 1'b0;
        pup_nxt[p] = 1'b0;
        pdn_nxt[p] = 1'b0;
        smt_nxt[p] = 1'b0;
      end
      smed_nxt[p]  = (slew_r[2*p +: 2] == SLEW_MEDIUM);
      shigh_nxt[p] = (slew_r[2*p +: 2] == SLEW_HIGH);
      inval_nxt[p] = smt_nxt[p] & stable_r[p];
      if (md == MODE_ALTFUNC) begin
        afin_nxt[16*p + int'(afs)] = inval_nxt[p];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pout_r  <= 16'h0000;
      poe_r   <= 16'h0000;
      pup_r   <= 16'h0000;
      pdn_r   <= 16'h0000;
      smt_r   <= 16'h0000;
      smed_r  <= 16'h0000;
      shigh_r <= 16'h0000;
      inval_r <= 16'h0000;
      afin_r  <= '0;
    end else begin
      pout_r  <= pout_nxt;
      poe_r   <= poe_nxt;
      pup_r   <= pup_nxt;
      pdn_r   <= pdn_nxt;
      smt_r   <= smt_nxt;
      smed_r  <= smed_nxt;
      shigh_r <= shigh_nxt;
      inval_r <= inval_nxt;
      afin_r  <= afin_nxt;
    end
  end

  // ********
  // Outputs
  // ********
  assign reg_rdata_o   = rdata_r;
  assign reg_ack_o     = ack_r;
  assign pin_out_o     = pout_r;
  assign pin_oe_o      = poe_r;
  assign pull_up_o     = pup_r;
  assign pull_down_o   = pdn_r;
  assign schmitt_en_o  = smt_r;
  assign slew_medium_o = smed_r;
  assign slew_high_o   = shigh_r;
  assign af_in_o       = afin_r;

endmodule // gpio_port_config_lock

`default_nettype wire

// file: common/gpio_lock_pkg.sv
// Constants for the sixteen-pin port with configuration freeze.
// Assumes a single bus clock domain and a 6-bit byte register address.
`default_nettype none

package gpio_lock_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_MODE   = 6'h00;
  localparam logic [5:0] OFS_DRIVE  = 6'h04;
  localparam logic [5:0] OFS_SLEW   = 6'h08;
  localparam logic [5:0] OFS_PULL   = 6'h0C;
  localparam logic [5:0] OFS_INPUT  = 6'h10;
  localparam logic [5:0] OFS_OUTPUT = 6'h14;
  localparam logic [5:0] OFS_FREEZE = 6'h1C;
  localparam logic [5:0] OFS_AF_LO  = 6'h20;
  localparam logic [5:0] OFS_AF_HI  = 6'h24;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int         FREEZE_KEY_POS = 16;
  localparam logic [3:0] FULL_WORD_BE   = 4'hF;
  localparam logic [1:0] MODE_INPUT     = 2'h0;
  localparam logic [1:0] MODE_OUTPUT    = 2'h1;
  localparam logic [1:0] MODE_ALTFUNC   = 2'h2;
  localparam logic [1:0] MODE_ANALOG    = 2'h3;
  localparam logic [1:0] SLEW_MEDIUM    = 2'h1;
  localparam logic [1:0] SLEW_HIGH      = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] MODE_RST_A  = 32'hA800_0000;
  localparam logic [31:0] MODE_RST_B  = 32'h0000_0280;
  localparam logic [31:0] SLEW_RST_A  = 32'h0C00_0000;
  localparam logic [31:0] SLEW_RST_B  = 32'h0000_00C0;
  localparam logic [31:0] PULL_RST_A  = 32'h6400_0000;
  localparam logic [31:0] PULL_RST_B  = 32'h0000_0100;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [1:0] port_kind_t;
  localparam port_kind_t PORT_A     = 2'h0;
  localparam port_kind_t PORT_B     = 2'h1;
  localparam port_kind_t PORT_OTHER = 2'h2;

  typedef enum logic [1:0] {
    FZ_IDLE,
    FZ_KEY_HI,
    FZ_KEY_LO
  } freeze_seq_e;

endpackage

`default_nettype wire

// file: tb/gpio_pad_world.sv
// Pad and peripheral world around the port: resolves each pin level
// from the port's drive and pulls, and feeds fixed peripheral channels.
`timescale 1ns/1ps
`default_nettype none

module gpio_pad_world (
  input  wire logic         mclk_i,
  input  wire logic [15:0]  pin_out_i,
  input  wire logic [15:0]  pin_oe_i,
  input  wire logic [15:0]  pull_up_i,
  input  wire logic [15:0]  pull_down_i,
  output logic      [15:0]  pin_lvl_o,
  output logic      [255:0] af_data_o,
  output logic      [255:0] af_oe_o
);
  // Undriven, unpulled pins wander every cycle
  logic [15:0] float_r = 16'h5555;

  always @(posedge mclk_i) begin
    float_r <= ~float_r;
  end

  // Channel c of every pin drives c[0], always enabled
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      if (pin_oe_i[p]) begin
        pin_lvl_o[p] = pin_out_i[p];
      end else if (pull_up_i[p]) begin
        pin_lvl_o[p] = 1'b1;
      end else if (pull_down_i[p]) begin
        pin_lvl_o[p] = 1'b0;
      end else begin
        pin_lvl_o[p] = float_r[p];
      end
      for (int c = 0; c < 16; c++) begin
        af_data_o[16*p+c] = c[0];
        af_oe_o[16*p+c]   = 1'b1;
      end
    end
  end
endmodule // gpio_pad_world

`default_nettype wire

// file: tb/gpio_port_config_lock_checker.sv
// Assertions on the port's register answers and pad controls.
// Assumes one bus clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_config_lock_checker
  import gpio_lock_pkg::*;
#(
  parameter logic [15:0] BACKUP_PINS      = 16'h0000,
  parameter int          FAST_OSC_IN_PIN  = 0,
  parameter int          FAST_FAST_OSC_OUTPUT_PIN_PIN = 1,
  parameter int          SLOW_OSC_IN_PIN  = 14
) (
  input  wire logic         mclk_i,
  input  wire logic         arst_n_i,
  input  wire logic         periph_rst_i,
  input  wire logic         reg_sel_i,
  input  wire logic         reg_wr_i,
  input  wire logic [5:0]   reg_addr_i,
  input  wire logic [31:0]  reg_rdata_o,
  input  wire logic         reg_ack_o,
  input  wire logic [15:0]  pin_oe_o,
  input  wire logic [15:0]  pull_up_o,
  input  wire logic [15:0]  pull_down_o,
  input  wire logic [15:0]  schmitt_en_o,
  input  wire logic [15:0]  slew_medium_o,
  input  wire logic [15:0]  slew_high_o,
  input  wire logic [255:0] af_in_o,
  input  wire logic         fast_osc_enable_i,
  input  wire logic         fast_osc_bypass_i,
  input  wire logic         slow_osc_enable_i,
  input  wire logic         slow_osc_bypass_i,
  input  wire logic         core_off_i,
  input  wire logic [15:0]  rtc_bypass_i
);
  logic       rd_r;
  logic [5:0] rd_addr_r;
  logic       key_r;
  logic       af_multi;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_r      <= 1'b0;
      rd_addr_r <= 6'h00;
      key_r     <= 1'b0;
    end else begin
      rd_r      <= reg_sel_i && !reg_wr_i && !periph_rst_i;
      rd_addr_r <= reg_addr_i;
      key_r     <= !periph_rst_i && (key_r || (reg_ack_o && rd_r && rd_addr_r == OFS_FREEZE
                   && reg_rdata_o[FREEZE_KEY_POS]));
    end
  end

  always_comb begin
    af_multi = 1'b0;
    for (int p = 0; p < 16; p++) begin
      if (!$onehot0(af_in_o[16*p +: 16])) begin
        af_multi = 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_fast_owned;
    (fast_osc_enable_i && !fast_osc_bypass_i) [*3];
  endsequence
  sequence s_slow_clkin;
    (slow_osc_enable_i && slow_osc_bypass_i) [*3];
  endsequence
  sequence s_core_off;
    (core_off_i && rtc_bypass_i == 16'h0000) [*3];
  endsequence

  property p_ack_exact;
    reg_ack_o == $past(reg_sel_i && !periph_rst_i);
  endproperty
  property p_data_upper;
    reg_ack_o && rd_r && (rd_addr_r == OFS_INPUT || rd_addr_r == OFS_OUTPUT) |-> reg_rdata_o[31:16] == 16'h0000;
  endproperty
  property p_key_sticky;
    reg_ack_o && rd_r && rd_addr_r == OFS_FREEZE && key_r |-> reg_rdata_o[FREEZE_KEY_POS];
  endproperty
  property p_af_single;
    !af_multi;
  endproperty
  property p_slew_decode;
    (slew_medium_o & slew_high_o) == 16'h0000;
  endproperty
  property p_fast_owned;
    s_fast_owned |-> !pin_oe_o[FAST_OSC_IN_PIN] && !pin_oe_o[FAST_FAST_OSC_OUTPUT_PIN_PIN]
      && !pull_up_o[FAST_FAST_OSC_OUTPUT_PIN_PIN] && !pull_down_o[FAST_FAST_OSC_OUTPUT_PIN_PIN];
  endproperty
  property p_slow_clkin;
    s_slow_clkin |-> !pin_oe_o[SLOW_OSC_IN_PIN] && !pull_up_o[SLOW_OSC_IN_PIN] && !pull_down_o[SLOW_OSC_IN_PIN];
  endproperty
  property p_backup_analog;
    s_core_off |-> ((pin_oe_o | pull_up_o | pull_down_o | schmitt_en_o) & BACKUP_PINS) == 16'h0000;
  endproperty

  a_ack_exact: assert property (p_ack_exact)
    else $error("ack not one cycle after access");
  a_data_upper: assert property (p_data_upper)
    else $error("data register upper half not zero");
  a_key_sticky: assert property (p_key_sticky)
    else $error("key bit dropped before reset");
  a_af_single: assert property (p_af_single)
    else $error("more than one channel per pin");
  a_slew_decode: assert property (p_slew_decode)
    else $error("medium and high speed together");
  a_fast_owned: assert property (p_fast_owned)
    else $error("fast oscillator pins still configured");
  a_slow_clkin: assert property (p_slow_clkin)
    else $error("slow clock input pin still configured");
  a_backup_analog: assert property (p_backup_analog)
    else $error("backup pin not analog while core off");
endmodule // gpio_port_config_lock_checker

bind gpio_port_config_lock gpio_port_config_lock_checker #(
  .BACKUP_PINS(BACKUP_PINS), .FAST_OSC_IN_PIN(FAST_OSC_IN_PIN),
  .FAST_FAST_OSC_OUTPUT_PIN_PIN(FAST_FAST_OSC_OUTPUT_PIN_PIN), .SLOW_OSC_IN_PIN(SLOW_OSC_IN_PIN)
) u_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .periph_rst_i(periph_rst_i), .reg_sel_i(reg_sel_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
  .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o), .schmitt_en_o(schmitt_en_o),
  .slew_medium_o(slew_medium_o), .slew_high_o(slew_high_o), .af_in_o(af_in_o),
  .fast_osc_enable_i(fast_osc_enable_i), .fast_osc_bypass_i(fast_osc_bypass_i),
  .slow_osc_enable_i(slow_osc_enable_i), .slow_osc_bypass_i(slow_osc_bypass_i),
  .core_off_i(core_off_i), .rtc_bypass_i(rtc_bypass_i)
);

`default_nettype wire

// file: tb/gpio_port_config_lock_tb_top.sv
// Self-checking bench for the configurable port with freeze.
// Assumes the pad world model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end

module gpio_port_config_lock_tb_top;
  import gpio_lock_pkg::*;

  logic mclk_i = 1'b0, arst_n_i = 1'b0, periph_rst_i = 1'b0;
  logic reg_sel_i = 1'b0, reg_wr_i = 1'b0, reg_ack_o;
  logic [5:0] reg_addr_i = 6'h00;
  logic [3:0] reg_be_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [15:0] pin_in_i, pin_out_o, pin_oe_o, pull_up_o, pull_down_o, schmitt_en_o;
  logic [15:0] slew_medium_o, slew_high_o, rtc_bypass_i = 16'h0000;
  logic [255:0] af_data_i, af_oe_i, af_in_o;
  logic fast_en = 1'b0, fast_byp = 1'b0, slow_en = 1'b0, slow_byp = 1'b0, core_off = 1'b0;
  int num_errors = 0, num_checks = 0;

  gpio_port_config_lock #(.PORT_KIND(PORT_A), .BACKUP_PINS(16'h3000)) dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .periph_rst_i(periph_rst_i), .reg_sel_i(reg_sel_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o), .schmitt_en_o(schmitt_en_o),
    .slew_medium_o(slew_medium_o), .slew_high_o(slew_high_o), .af_data_i(af_data_i), .af_oe_i(af_oe_i),
    .af_in_o(af_in_o), .fast_osc_enable_i(fast_en), .fast_osc_bypass_i(fast_byp),
    .slow_osc_enable_i(slow_en), .slow_osc_bypass_i(slow_byp), .core_off_i(core_off),
    .rtc_bypass_i(rtc_bypass_i));

  gpio_pad_world u_world (
    .mclk_i(mclk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pull_up_i(pull_up_o),
    .pull_down_i(pull_down_o), .pin_lvl_o(pin_in_i), .af_data_o(af_data_i), .af_oe_o(af_oe_i));

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  // ********
  // Register access tasks
  // ********
  task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] be, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge mclk_i);
    {reg_sel_i, reg_wr_i, reg_addr_i, reg_be_i, reg_wdata_i} = {1'b1, w, a, be, d};
    @(negedge mclk_i);
    reg_sel_i = 1'b0;
    q = reg_rdata_o;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, FULL_WORD_BE, d, q);
  endtask

  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    acc(1'b0, a, 4'h0, 32'h0, q);
    `CHK(nm, e & m, q & m)
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset_values();
    rdc("mode", OFS_MODE, MODE_RST_A);
    rdc("slew", OFS_SLEW, SLEW_RST_A);
    rdc("pull", OFS_PULL, PULL_RST_A);
    rdc("drive", OFS_DRIVE, ZERO_RST);
    rdc("outreg", OFS_OUTPUT, ZERO_RST);
    rdc("freeze", OFS_FREEZE, ZERO_RST);
    rdc("unmapped", 6'h18, ZERO_RST);
  endtask

  task automatic t_narrow_writes();
    logic [31:0] q;
    acc(1'b1, OFS_OUTPUT, 4'h2, 32'hFFFF_FFFF, q);
    rdc("outreg byte", OFS_OUTPUT, 32'h0000_FF00);
    acc(1'b1, OFS_SLEW, 4'hC, 32'h1234_5678, q);
    rdc("slew half", OFS_SLEW, 32'h1234_0000);
    settle(2);
    `CHK("slew decode", 32'h0400_0200, {slew_high_o, slew_medium_o} & 32'h1F00_1F00)
  endtask

  task automatic t_modes();
    wr(OFS_MODE, 32'h0002_00E4);
    wr(OFS_PULL, 32'h0000_0041);
    wr(OFS_OUTPUT, 32'h0000_000F);
    wr(OFS_AF_LO, 32'h0000_0100);
    wr(OFS_AF_HI, 32'h0000_000F);
    settle(2);
    `CHK("oe", 5'h16, {pin_oe_o[8], pin_oe_o[3:0]})
    `CHK("out", 3'h7, {pin_out_o[8], pin_out_o[2:1]})
    `CHK("pullup", 4'h1, pull_up_o[3:0])
    `CHK("schmitt", 4'h7, schmitt_en_o[3:0])
    settle(8);
    rdc("inreg", OFS_INPUT, 32'h0000_0007, 32'h0000_000F);
    `CHK("af in", 16'h0002, af_in_o[47:32])
    wr(OFS_DRIVE, 32'h0000_0002);
    settle(2);
    `CHK("od high", 1'b0, pin_oe_o[1])
    wr(OFS_OUTPUT, 32'h0000_0000);
    wr(OFS_AF_LO, 32'h0000_0200);
    settle(2);
    `CHK("od low", 3'h4, {pin_oe_o[1], pin_out_o[1], pin_out_o[2]})
  endtask

  task automatic t_oscillators();
    fast_en = 1'b1;
    settle(4);
    `CHK("fast osc oe", 2'h0, pin_oe_o[1:0])
    fast_byp = 1'b1;
    slow_en = 1'b1;
    slow_byp = 1'b1;
    settle(4);
    {fast_en, fast_byp, slow_en, slow_byp} = 4'h0;
    settle(4);
    `CHK("osc released", 1'b1, pin_oe_o[1])
  endtask

  task automatic t_freeze();
    logic [31:0] q;
    logic [5:0] ofs[4] = '{OFS_MODE, OFS_SLEW, OFS_PULL, OFS_AF_LO};
    logic [31:0] exp[4] = '{32'hFFFF_FFF4, 32'hFFFF_FFF0, 32'hFFFF_FFF1, 32'hFFFF_FF00};
    wr(OFS_FREEZE, 32'h0001_0003);
    wr(OFS_FREEZE, 32'h0000_0003);
    wr(OFS_FREEZE, 32'h0001_0007);
    rdc("key mask change", OFS_FREEZE, 32'h0, 32'h0001_0000);
    wr(OFS_FREEZE, 32'h0001_0003);
    wr(OFS_FREEZE, 32'h0000_0003);
    acc(1'b1, OFS_FREEZE, 4'h7, 32'h0001_0003, q);
    rdc("key narrow", OFS_FREEZE, 32'h0, 32'h0001_0000);
    wr(OFS_FREEZE, 32'h0001_0003);
    wr(OFS_FREEZE, 32'h0000_0003);
    wr(OFS_FREEZE, 32'h0001_0003);
    rdc("key set", OFS_FREEZE, 32'h0001_0003);
    wr(OFS_FREEZE, 32'h0000_FFFF);
    rdc("key kept", OFS_FREEZE, 32'h0001_0003);
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 32'hFFFF_FFFF);
      rdc("frozen field", ofs[i], exp[i]);
    end
    @(negedge mclk_i);
    periph_rst_i = 1'b1;
    @(negedge mclk_i);
    periph_rst_i = 1'b0;
    rdc("freeze cleared", OFS_FREEZE, ZERO_RST);
    rdc("mode reset", OFS_MODE, MODE_RST_A);
  endtask

  task automatic t_backup();
    settle(2);
    `CHK("pin13 pull", 1'b1, pull_up_o[13])
    core_off = 1'b1;
    settle(4);
    `CHK("backup off", 2'h0, {pull_up_o[13], schmitt_en_o[13]})
    rtc_bypass_i = 16'h2000;
    settle(4);
    `CHK("rtc bypass", 1'b1, pull_up_o[13])
    {core_off, rtc_bypass_i} = 17'h0;
  endtask

  // ********
  // Verdict
  // ********
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    arst_n_i = 1'b1;
    t_reset_values();
    t_narrow_writes();
    t_modes();
    t_oscillators();
    t_freeze();
    t_backup();
    test_done();
  end
endmodule // gpio_port_config_lock_tb_top

`default_nettype wire
